/* hw/seq_pkg.sv */
// Package with register map, field layout, reset values, timing and types of the setpoint program sequencer.
//
// Contract
// - Four program choices, default program one only.
// - Input low picks one; latched at start.
// - Cascade runs program one then program two.
// - Hold threshold off or 0.1-10 percent.
// - Hold compared only at interval end.
// - Program one has ten durations, format-dependent.
// - Program two has five durations, same ranges.
// - Targets -10 to 110 percent, or none.
// - Start from internal setpoint; ends chain onward.
// - No-point targets interpolate between defined neighbours.
// - Six outputs driven per interval, default low.
// - End-state level per program after end, start.
// - Cascade runs up to fifteen intervals.
package seq_pkg;

  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_HOLD     = 12'h004;
  localparam logic [11:0] OFS_STATUS   = 12'h008;
  localparam logic [11:0] OFS_WINT     = 12'h00C;
  localparam logic [11:0] OFS_SETPOINT = 12'h010;
  localparam logic [11:0] OFS_END_LVL1 = 12'h014;
  localparam logic [11:0] OFS_END_LVL2 = 12'h018;
  localparam logic [11:0] OFS_DUR_BASE = 12'h040;
  localparam logic [11:0] OFS_TGT_BASE = 12'h080;
  localparam logic [11:0] OFS_LVL_BASE = 12'h0C0;

  // Field positions.
  localparam int CTRL_CHOICE_LSB = 0;
  localparam int CTRL_FORMAT_BIT = 2;
  localparam int CTRL_START_BIT  = 3;
  localparam int CTRL_ABORT_BIT  = 4;
  localparam int DUR_MAJOR_LSB   = 8;
  localparam int DUR_MINOR_LSB   = 0;
  localparam int TGT_NOP_BIT     = 16;

  // Table sizes.
  localparam int N_P1  = 10;
  localparam int N_P2  = 5;
  localparam int N_IV  = 15;
  localparam int N_OUT = 6;

  // Reset values and limits; analog values are signed tenths of a percent of scale.
  localparam logic [1:0]        CHOICE_RST = 2'h0;
  localparam logic              FORMAT_RST = 1'b0;
  localparam logic [7:0]        HOLD_RST   = 8'h00;
  localparam logic [7:0]        HOLD_MAX   = 8'h64;
  localparam logic signed [15:0] TGT_MIN   = 16'hFF9C;
  localparam logic signed [15:0] TGT_MAX   = 16'h044C;
  localparam logic [15:0]       TGT_RST    = 16'h0000;
  localparam logic [5:0]        LVL_RST    = 6'h00;
  localparam logic [11:0]       DUR_RST    = 12'h000;
  localparam logic [5:0]        FIELD_MAX  = 6'h3B;

  // Timing.
  localparam int CLK_PERIOD_NS      = 10;
  localparam int SECOND_NS          = 1_000_000_000;
  localparam int CYCLES_PER_SECOND  = SECOND_NS / CLK_PERIOD_NS;
  localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3C;
  localparam logic [15:0] MINOR_PER_MAJOR   = 16'h003C;

  // Ramp divider widths.
  localparam int NUM_W = 27;
  localparam int DEN_W = 16;

  typedef enum logic [1:0] {
    CHOICE_P1   = 2'b00,
    CHOICE_P2   = 2'b01,
    CHOICE_PIN  = 2'b10,
    CHOICE_CASCADED_SELECTION = 2'b11
  } choice_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_SCAN = 3'b010,
    ST_RUN  = 3'b011,
    ST_HOLD = 3'b100,
    ST_DONE = 3'b101
  } state_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

endpackage

/* hw/seq_ramp_divider.sv */
// Restoring unsigned divider that scales the ramp step, one quotient bit per cycle.
module seq_ramp_divider (
  // Clock and reset.
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // Request.
  input  wire logic                       start,
  input  wire logic [seq_pkg::NUM_W-1:0]  numer,
  input  wire logic [seq_pkg::DEN_W-1:0]  denom,
  // Result.
  output logic                            done,
  output logic [seq_pkg::NUM_W-1:0]       quot
);

  logic [seq_pkg::NUM_W-1:0] q_ff;
  logic [seq_pkg::DEN_W-1:0] rem_ff;
  logic [seq_pkg::DEN_W-1:0] den_ff;
  logic [4:0]                cnt_ff;
  logic                      done_ff;
  logic [seq_pkg::DEN_W:0]   trial;
  logic                      fits;

  // Shift one numerator bit into the partial remainder and try the subtraction.
  always_comb begin
    trial = {rem_ff, q_ff[seq_pkg::NUM_W-1]};
    fits  = (trial >= {1'b0, den_ff});
  end

  // A new start overrides a division still in flight.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q_ff    <= '0;
      rem_ff  <= '0;
      den_ff  <= '0;
      cnt_ff  <= 5'h00;
      done_ff <= 1'b0;
    end else if (start) begin
      q_ff    <= numer;
      rem_ff  <= '0;
      den_ff  <= denom;
      cnt_ff  <= 5'(seq_pkg::NUM_W);
      done_ff <= 1'b0;
    end else begin
      done_ff <= (cnt_ff == 5'h01);
      if (cnt_ff != 5'h00) begin
        cnt_ff <= cnt_ff - 5'h01;
        q_ff   <= {q_ff[seq_pkg::NUM_W-2:0], fits};
        rem_ff <= fits ? 16'(trial - {1'b0, den_ff}) : trial[seq_pkg::DEN_W-1:0];
      end
    end
  end

  assign done = done_ff;
  assign quot = q_ff;

endmodule

/* hw/seq_tick_divider.sv */
// Divider that turns the system clock into second and minute enable pulses.
module seq_tick_divider #(
  parameter int CYCLES_PER_SECOND = seq_pkg::CYCLES_PER_SECOND
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Restart so a fresh interval counts whole units.
  input  wire logic clear,
  // One-cycle enables.
  output logic      sec_tick,
  output logic      min_tick
);

  logic [31:0] cyc_ff;
  logic [5:0]  sec_ff;
  logic        sec_tick_ff;
  logic        min_tick_ff;

  // Cycle counter wraps once per second.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cyc_ff      <= 32'h0000_0000;
      sec_tick_ff <= 1'b0;
    end else if (clear) begin
      cyc_ff      <= 32'h0000_0000;
      sec_tick_ff <= 1'b0;
    end else begin
      sec_tick_ff <= (cyc_ff == 32'(CYCLES_PER_SECOND - 1));
      cyc_ff      <= (cyc_ff == 32'(CYCLES_PER_SECOND - 1)) ? 32'h0000_0000 : cyc_ff + 32'h0000_0001;
    end
  end

  // Second counter makes the minute pulse, aligned with a second pulse.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sec_ff      <= 6'h00;
      min_tick_ff <= 1'b0;
    end else if (clear) begin
      sec_ff      <= 6'h00;
      min_tick_ff <= 1'b0;
    end else begin
      min_tick_ff <= 1'b0;
      if (cyc_ff == 32'(CYCLES_PER_SECOND - 1)) begin
        min_tick_ff <= (sec_ff == seq_pkg::SECONDS_PER_MINUTE - 6'h01);
        sec_ff      <= (sec_ff == seq_pkg::SECONDS_PER_MINUTE - 6'h01) ? 6'h00 : sec_ff + 6'h01;
      end
    end
  end

  assign sec_tick = sec_tick_ff;
  assign min_tick = min_tick_ff;

endmodule

/* hw/setpoint_program_sequencer.sv */
// Setpoint program sequencer: APB register file, interval tables and the program state machine.
//
// The address map and the APB interface to the registers are this design's own decisions.
module setpoint_program_sequencer #(
  parameter int CYCLES_PER_SECOND = seq_pkg::CYCLES_PER_SECOND
) (
  // Clock and reset.
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // APB slave.
  input  wire seq_pkg::apb_req_type    apb_req,
  output seq_pkg::apb_rsp_type         apb_rsp,
  // Control loop and plant.
  input  wire logic                    program_choice_input,
  input  wire logic signed [15:0]      control_difference,
  output logic signed [15:0]           setpoint_out,
  output logic [seq_pkg::N_OUT-1:0]    sequence_outputs,
  output logic                         program_running
);

  seq_pkg::apb_rsp_type    rsp_ff;
  seq_pkg::state_type      state_ff;
  seq_pkg::choice_type     program_choice_ff;
  logic                    time_format_ff;
  logic [7:0]              hold_ff;
  logic signed [15:0]      internal_setpoint_ff;
  logic [5:0]              end_lvl1_ff;
  logic [5:0]              end_lvl2_ff;
  logic [11:0]             dur_ff [0:seq_pkg::N_IV-1];
  logic [16:0]             tgt_ff [0:seq_pkg::N_IV-1];
  logic [5:0]              lvl_ff [0:seq_pkg::N_IV-1];
  logic [3:0]              idx_ff;
  logic [3:0]              last_ff;
  logic [3:0]              scan_ff;
  logic                    use_p2_end_ff;
  logic signed [15:0]      sp_ff;
  logic signed [15:0]      base_ff;
  logic signed [15:0]      goal_ff;
  logic [15:0]             seg_total_ff;
  logic [15:0]             seg_done_ff;
  logic [15:0]             acc_ff;
  logic [15:0]             iv_left_ff;
  logic                    neg_ff;
  logic [5:0]              out_ff;
  logic                    run_ff;
  logic                    div_start_ff;

  // Bus decode.
  logic                    setup;
  logic                    wr_en;
  logic [11:0]             addr;
  logic [31:0]             wdata;
  logic                    tbl_ok;
  logic [3:0]              ent;
  logic [31:0]             rd_data;
  logic                    rd_ok;
  logic                    start_req;
  logic                    abort_req;
  logic                    prog_two;
  logic                    unit_tick;
  logic                    sec_tick;
  logic                    min_tick;
  logic                    div_done;
  logic [seq_pkg::NUM_W-1:0] quot;
  logic [15:0]             diff_mag;
  logic signed [15:0]      wtgt;
  logic [5:0]              wmaj;
  logic [5:0]              wmin;
  logic [10:0]             delta_mag;

  // Interval length in timer units: major field times sixty plus minor field.
  function automatic logic [15:0] units_of(input logic [11:0] d);
    units_of = 16'(d[11:6]) * seq_pkg::MINOR_PER_MAJOR + 16'(d[5:0]);
  endfunction

  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & rsp_ff.pready;
  assign addr  = apb_req.paddr;
  assign wdata = apb_req.pwdata;
  assign ent   = addr[5:2];
  assign tbl_ok = (addr[1:0] == 2'b00) && (ent < 4'(seq_pkg::N_IV));
  assign start_req = wr_en && (addr == seq_pkg::OFS_CTRL) && wdata[seq_pkg::CTRL_START_BIT];
  assign abort_req = wr_en && (addr == seq_pkg::OFS_CTRL) && wdata[seq_pkg::CTRL_ABORT_BIT];

  // Read mux; unmapped addresses answer with an error and zero data.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (addr == seq_pkg::OFS_CTRL) begin
      rd_data = {29'h0000_0000, time_format_ff, program_choice_ff};
    end else if (addr == seq_pkg::OFS_HOLD) begin
      rd_data = {24'h00_0000, hold_ff};
    end else if (addr == seq_pkg::OFS_STATUS) begin
      rd_data = {24'h00_0000, idx_ff, 1'b0, state_ff};
    end else if (addr == seq_pkg::OFS_WINT) begin
      rd_data = {16'h0000, internal_setpoint_ff};
    end else if (addr == seq_pkg::OFS_SETPOINT) begin
      rd_data = {16'h0000, sp_ff};
    end else if (addr == seq_pkg::OFS_END_LVL1) begin
      rd_data = {26'h000_0000, end_lvl1_ff};
    end else if (addr == seq_pkg::OFS_END_LVL2) begin
      rd_data = {26'h000_0000, end_lvl2_ff};
    end else if (addr[11:6] == seq_pkg::OFS_DUR_BASE[11:6] && tbl_ok) begin
      rd_data = {18'h0_0000, dur_ff[ent][11:6], 2'b00, dur_ff[ent][5:0]};
    end else if (addr[11:6] == seq_pkg::OFS_TGT_BASE[11:6] && tbl_ok) begin
      rd_data = {15'h0000, tgt_ff[ent]};
    end else if (addr[11:6] == seq_pkg::OFS_LVL_BASE[11:6] && tbl_ok) begin
      rd_data = {26'h000_0000, lvl_ff[ent]};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Answer one cycle after setup, so every access phase is exactly one cycle long.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.pready  <= setup;
      rsp_ff.pslverr <= setup & ~rd_ok;
      rsp_ff.prdata  <= (setup & ~apb_req.pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // Write values are clamped into their legal ranges.
  always_comb begin
    wtgt = wdata[15:0];
    if (wtgt < seq_pkg::TGT_MIN) begin
      wtgt = seq_pkg::TGT_MIN;
    end else if (wtgt > seq_pkg::TGT_MAX) begin
      wtgt = seq_pkg::TGT_MAX;
    end
    wmaj = (wdata[13:8] > seq_pkg::FIELD_MAX) ? seq_pkg::FIELD_MAX : wdata[13:8];
    wmin = (wdata[5:0] > seq_pkg::FIELD_MAX) ? seq_pkg::FIELD_MAX : wdata[5:0];
  end

  // Configuration registers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      program_choice_ff    <= seq_pkg::choice_type'(seq_pkg::CHOICE_RST);
      time_format_ff       <= seq_pkg::FORMAT_RST;
      hold_ff              <= seq_pkg::HOLD_RST;
      internal_setpoint_ff <= seq_pkg::TGT_RST;
      end_lvl1_ff          <= seq_pkg::LVL_RST;
      end_lvl2_ff          <= seq_pkg::LVL_RST;
    end else if (wr_en) begin
      if (addr == seq_pkg::OFS_CTRL) begin
        program_choice_ff <= seq_pkg::choice_type'(wdata[seq_pkg::CTRL_CHOICE_LSB +: 2]);
        time_format_ff    <= wdata[seq_pkg::CTRL_FORMAT_BIT];
      end
      if (addr == seq_pkg::OFS_HOLD) begin
        hold_ff <= (wdata[7:0] > seq_pkg::HOLD_MAX) ? seq_pkg::HOLD_MAX : wdata[7:0];
      end
      if (addr == seq_pkg::OFS_WINT) begin
        internal_setpoint_ff <= wtgt;
      end
      if (addr == seq_pkg::OFS_END_LVL1) begin
        end_lvl1_ff <= wdata[5:0];
      end
      if (addr == seq_pkg::OFS_END_LVL2) begin
        end_lvl2_ff <= wdata[5:0];
      end
    end
  end

  // Interval tables: entries 0-9 belong to program one, 10-14 to program two.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < seq_pkg::N_IV; i++) begin
        dur_ff[i] <= seq_pkg::DUR_RST;
        tgt_ff[i] <= {1'b0, seq_pkg::TGT_RST};
        lvl_ff[i] <= seq_pkg::LVL_RST;
      end
    end else if (wr_en && tbl_ok) begin
      if (addr[11:6] == seq_pkg::OFS_DUR_BASE[11:6]) begin
        dur_ff[ent] <= {wmaj, wmin};
      end
      if (addr[11:6] == seq_pkg::OFS_TGT_BASE[11:6]) begin
        tgt_ff[ent] <= {wdata[seq_pkg::TGT_NOP_BIT], wtgt};
      end
      if (addr[11:6] == seq_pkg::OFS_LVL_BASE[11:6]) begin
        lvl_ff[ent] <= wdata[5:0];
      end
    end
  end

  // Pin choice matters at start and for the end-state level shown while idle; it is not looked at while running.
  assign prog_two  = (program_choice_ff == seq_pkg::CHOICE_P2) ||
                     (program_choice_ff == seq_pkg::CHOICE_PIN && program_choice_input);
  assign unit_tick = time_format_ff ? sec_tick : min_tick;
  assign diff_mag  = control_difference[15] ? 16'(-control_difference) : control_difference;

  seq_tick_divider #(
    .CYCLES_PER_SECOND (CYCLES_PER_SECOND)
  ) u_tick (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clear    (state_ff != seq_pkg::ST_RUN),
    .sec_tick (sec_tick),
    .min_tick (min_tick)
  );

  assign delta_mag = neg_ff ? 11'(base_ff - goal_ff) : 11'(goal_ff - base_ff);

  seq_ramp_divider u_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (div_start_ff),
    .numer   (27'(delta_mag) * 27'(seg_done_ff)),
    .denom   (seg_total_ff),
    .done    (div_done),
    .quot    (quot)
  );

  // Program state machine.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff      <= seq_pkg::ST_IDLE;
      idx_ff        <= 4'h0;
      last_ff       <= 4'h0;
      scan_ff       <= 4'h0;
      use_p2_end_ff <= 1'b0;
      base_ff       <= 16'h0000;
      goal_ff       <= 16'h0000;
      neg_ff        <= 1'b0;
      seg_total_ff  <= 16'h0000;
      seg_done_ff   <= 16'h0000;
      acc_ff        <= 16'h0000;
      iv_left_ff    <= 16'h0000;
      div_start_ff  <= 1'b0;
    end else begin
      div_start_ff <= 1'b0;
      case (state_ff)
        seq_pkg::ST_IDLE, seq_pkg::ST_DONE: begin
          if (start_req) begin
            state_ff      <= seq_pkg::ST_LOAD;
            idx_ff        <= prog_two ? 4'(seq_pkg::N_P1) : 4'h0;
            last_ff       <= (prog_two || program_choice_ff == seq_pkg::CHOICE_CASCADED_SELECTION) ?
                             4'(seq_pkg::N_IV - 1) : 4'(seq_pkg::N_P1 - 1);
            use_p2_end_ff <= prog_two || program_choice_ff == seq_pkg::CHOICE_CASCADED_SELECTION;
            seg_total_ff  <= 16'h0000;
            seg_done_ff   <= 16'h0000;
          end
        end
        seq_pkg::ST_LOAD: begin
          if (abort_req) begin
            state_ff <= seq_pkg::ST_IDLE;
          end else if (idx_ff > last_ff) begin
            state_ff <= seq_pkg::ST_DONE;
          end else if (dur_ff[idx_ff] == seq_pkg::DUR_RST) begin
            idx_ff <= idx_ff + 4'h1;
          end else begin
            iv_left_ff <= units_of(dur_ff[idx_ff]);
            if (seg_done_ff == seg_total_ff) begin
              // The previous segment ended on a defined point, so a new one starts here.
              base_ff  <= sp_ff;
              scan_ff  <= idx_ff;
              acc_ff   <= 16'h0000;
              state_ff <= seq_pkg::ST_SCAN;
            end else begin
              state_ff <= seq_pkg::ST_RUN;
            end
          end
        end
        seq_pkg::ST_SCAN: begin
          // Walk forward to the next defined point; no-point intervals share one straight line.
          if (scan_ff > last_ff) begin
            goal_ff      <= base_ff;
            neg_ff       <= 1'b0;
            seg_total_ff <= acc_ff;
            seg_done_ff  <= 16'h0000;
            state_ff     <= seq_pkg::ST_RUN;
          end else if (dur_ff[scan_ff] == seq_pkg::DUR_RST) begin
            scan_ff <= scan_ff + 4'h1;
          end else if (!tgt_ff[scan_ff][seq_pkg::TGT_NOP_BIT]) begin
            goal_ff      <= tgt_ff[scan_ff][15:0];
            neg_ff       <= $signed(tgt_ff[scan_ff][15:0]) < base_ff;
            seg_total_ff <= acc_ff + units_of(dur_ff[scan_ff]);
            seg_done_ff  <= 16'h0000;
            state_ff     <= seq_pkg::ST_RUN;
          end else begin
            acc_ff  <= acc_ff + units_of(dur_ff[scan_ff]);
            scan_ff <= scan_ff + 4'h1;
          end
        end
        seq_pkg::ST_RUN: begin
          if (abort_req) begin
            state_ff <= seq_pkg::ST_IDLE;
          end else if (unit_tick) begin
            seg_done_ff  <= seg_done_ff + 16'h0001;
            iv_left_ff   <= iv_left_ff - 16'h0001;
            div_start_ff <= (seg_done_ff + 16'h0001 != seg_total_ff);
            if (iv_left_ff == 16'h0001) begin
              // The control difference is only judged here, at the end of the interval.
              if (hold_ff != seq_pkg::HOLD_RST && diff_mag >= 16'(hold_ff)) begin
                state_ff <= seq_pkg::ST_HOLD;
              end else begin
                idx_ff   <= idx_ff + 4'h1;
                state_ff <= seq_pkg::ST_LOAD;
              end
            end
          end
        end
        seq_pkg::ST_HOLD: begin
          if (abort_req) begin
            state_ff <= seq_pkg::ST_IDLE;
          end else if (diff_mag < 16'(hold_ff)) begin
            idx_ff   <= idx_ff + 4'h1;
            state_ff <= seq_pkg::ST_LOAD;
          end
        end
        default: begin
          state_ff <= seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Setpoint: internal value while idle, exact goal at segment end, scaled ramp in between.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sp_ff <= 16'h0000;
    end else if (state_ff == seq_pkg::ST_IDLE || (state_ff == seq_pkg::ST_DONE && start_req)) begin
      // A restart from the end state ramps from the internal setpoint again.
      sp_ff <= internal_setpoint_ff;
    end else if (state_ff == seq_pkg::ST_RUN && unit_tick && seg_done_ff + 16'h0001 == seg_total_ff) begin
      sp_ff <= goal_ff;
    end else if (div_done && state_ff != seq_pkg::ST_DONE) begin
      sp_ff <= neg_ff ? base_ff - 16'(quot) : base_ff + 16'(quot);
    end
  end

  // Digital outputs: interval level while timing or holding, end-state level while idle or done, unchanged during load and scan.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_ff <= seq_pkg::LVL_RST;
      run_ff <= 1'b0;
    end else begin
      run_ff <= (state_ff != seq_pkg::ST_IDLE) && (state_ff != seq_pkg::ST_DONE);
      if (state_ff == seq_pkg::ST_RUN || state_ff == seq_pkg::ST_HOLD) begin
        out_ff <= lvl_ff[idx_ff];
      end else if (state_ff == seq_pkg::ST_DONE) begin
        out_ff <= use_p2_end_ff ? end_lvl2_ff : end_lvl1_ff;
      end else if (state_ff == seq_pkg::ST_IDLE) begin
        out_ff <= prog_two ? end_lvl2_ff : end_lvl1_ff;
      end
    end
  end

  assign apb_rsp          = rsp_ff;
  assign setpoint_out     = sp_ff;
  assign sequence_outputs = out_ff;
  assign program_running  = run_ff;

endmodule

/* tb/seq_checker.sv */
// Checker for the sequencer's bus answers and its plant-side outputs.
module seq_checker #(
  parameter int CYCLES_PER_SECOND = 100
) (
  // Clock and reset.
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  // Bus and plant side.
  input wire seq_pkg::apb_req_type  apb_req,
  input wire seq_pkg::apb_rsp_type  apb_rsp,
  input wire logic                  program_choice_input,
  input wire logic signed [15:0]    control_difference,
  input wire logic signed [15:0]    setpoint_out,
  input wire logic [5:0]            sequence_outputs,
  input wire logic                  program_running
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // A finished write is the only thing that may launch a run.
  logic wr_done;
  assign wr_done = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
  sequence setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence answer_s;
    apb_rsp.pready ##1 !apb_rsp.pready;
  endsequence
  a_ready_next: assert property (setup_s |=> answer_s) else $error("no single answer after setup");
  a_ready_cause: assert property (apb_rsp.pready |-> $past(apb_req.psel && !apb_req.penable))
    else $error("answer without setup");
  a_ready_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable) else $error("answer off access");
  a_err_nodata: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == '0) else $error("bad error");
  a_write_nodata: assert property (apb_rsp.pready && apb_req.pwrite |-> apb_rsp.prdata == '0) else $error("write data");
  a_sp_range: assert property (setpoint_out >= -16'sd100 && setpoint_out <= 16'sd1100) else $error("range");
  a_run_cause: assert property ($rose(program_running) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
    else $error("run without start");
  a_run_ack: assert property ($rose(program_running) |-> !apb_rsp.pslverr) else $error("run after error");
endmodule

/* tb/seq_plant_model.sv */
// Plant model: follows the setpoint one cycle late, or lags far behind when stalled.
module seq_plant_model (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic                stall,
  input wire logic signed [15:0]  setpoint_out,
  output logic signed [15:0]      control_difference
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [15:0] actual_ff;
  // The actual value trails by one cycle, so a steady setpoint leaves no difference.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) actual_ff <= '0;
    else actual_ff <= setpoint_out;
  end
  assign control_difference = stall ? 16'sh01F4 : setpoint_out - actual_ff;
endmodule

/* tb/tb_top.sv */
// Testbench for the setpoint program sequencer.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_sys = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 program_choice_input = 1'b0;
  logic                 stall = 1'b0;
  seq_pkg::apb_req_type apb_req = '0;
  seq_pkg::apb_rsp_type apb_rsp;
  logic signed [15:0]   control_difference;
  logic signed [15:0]   setpoint_out;
  logic [5:0]           sequence_outputs;
  logic                 program_running;
  logic [31:0]          rd;
  logic                 err;
  int                   bad_count = 0;
  int                   tests_run = 0;
  int                   n;
  always #5 clk_sys = ~clk_sys;
  setpoint_program_sequencer #(.CYCLES_PER_SECOND(100)) setpoint_program_sequencer_inst (.clk_sys, .rst_n, .apb_req,
    .apb_rsp, .program_choice_input, .control_difference, .setpoint_out, .sequence_outputs, .program_running);
  seq_plant_model seq_plant_model_inst (.clk_sys, .rst_n, .stall, .setpoint_out, .control_difference);
  task automatic complete_run;
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic give_up;
    bad_count++;
    $display("CHECK FAILED %0t: wait ran out", $time);
    complete_run;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is sampled high.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) give_up;
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  // Waits, with a bound, until the outputs show a level or the run ends; n keeps the cycles spent.
  task automatic wait_for(input logic [6:0] v);
    for (n = 0; n < 8000; n++) begin
      @(posedge clk_sys);
      if (v[6] ? program_running === 1'b0 : sequence_outputs === v[5:0]) return;
    end
    give_up;
  endtask
  task automatic check_reset;
    logic [11:0] a[7] = '{12'h000, 12'h004, 12'h040, 12'h078, 12'h080, 12'h0C0, 12'h018};
    foreach (a[i]) begin
      xfer(1'b0, a[i], '0);
      chk(rd, '0);
    end
    xfer(1'b1, 12'h07C, 32'h0000_0001);
    chk({31'h0, err}, 32'h0000_0001);
    chk({setpoint_out, 10'h0, sequence_outputs}, '0);
  endtask
  // Program one: a no-point end, a skipped zero interval, then a defined end; other durations stay 00.00.
  task automatic run_no_point;
    xfer(1'b1, 12'h040, 32'h0000_0002);
    xfer(1'b1, 12'h080, 32'h0001_0000);
    xfer(1'b1, 12'h0C0, 32'h0000_0015);
    xfer(1'b1, 12'h048, 32'h0000_0001);
    xfer(1'b1, 12'h088, 32'h0000_012C);
    xfer(1'b1, 12'h0C8, 32'h0000_002A);
    xfer(1'b1, 12'h014, 32'h0000_003F);
    xfer(1'b1, 12'h000, 32'h0000_000C);
    wait_for(7'h15);
    wait_for(7'h2A);
    chk(n > 195 && n < 215, 1);
    repeat (40) @(posedge clk_sys);
    chk(setpoint_out, 32'h0000_00C8);
    wait_for(7'h40);
    chk({setpoint_out, 10'h0, sequence_outputs}, 32'h012C_003F);
  endtask
  // Program two picked by the pin, which then moves during the run; the plant stalls the hold.
  task automatic run_pin_hold;
    xfer(1'b1, 12'h068, 32'h0000_0001);
    xfer(1'b1, 12'h0A8, 32'h0000_FF9C);
    xfer(1'b1, 12'h0E8, 32'h0000_0007);
    xfer(1'b1, 12'h018, 32'h0000_0021);
    xfer(1'b1, 12'h004, 32'h0000_000A);
    program_choice_input <= 1'b1;
    stall <= 1'b1;
    xfer(1'b1, 12'h000, 32'h0000_0006);
    xfer(1'b1, 12'h000, 32'h0000_000E);
    program_choice_input <= 1'b0;
    wait_for(7'h07);
    chk(setpoint_out, '0);
    repeat (250) @(posedge clk_sys);
    xfer(1'b0, 12'h008, '0);
    chk({program_running, rd[2:0]}, 32'h0000_000C);
    stall <= 1'b0;
    wait_for(7'h40);
    chk(n < 40, 1);
    chk({setpoint_out, 10'h0, sequence_outputs}, 32'hFF9C_0021);
  endtask
  // Cascade with the hold off: every program one interval, then program two.
  task automatic run_cascade;
    xfer(1'b1, 12'h004, 32'h0000_0000);
    xfer(1'b1, 12'h000, 32'h0000_0007);
    xfer(1'b1, 12'h000, 32'h0000_000F);
    wait_for(7'h15);
    wait_for(7'h2A);
    wait_for(7'h07);
    wait_for(7'h40);
    chk({setpoint_out, 10'h0, sequence_outputs}, 32'hFF9C_0021);
  endtask
  // Program two alone at the minute rate: only interval ten runs, for one minute.
  task automatic run_p2_minutes;
    xfer(1'b1, 12'h000, 32'h0000_0001);
    xfer(1'b1, 12'h000, 32'h0000_0009);
    wait_for(7'h07);
    wait_for(7'h40);
    chk(n > 6000 && n < 6150, 1);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    check_reset;
    run_no_point;
    run_pin_hold;
    run_cascade;
    run_p2_minutes;
    complete_run;
  end
endmodule
bind setpoint_program_sequencer seq_checker #(.CYCLES_PER_SECOND(CYCLES_PER_SECOND)) seq_checker_inst (.clk_sys,
  .rst_n, .apb_req, .apb_rsp, .program_choice_input, .control_difference, .setpoint_out, .sequence_outputs,
  .program_running);
